//--- src/isvu_top.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// R1 - maskable requests need enable flag and priority; non-maskable ignore both
// R2 - trap instructions are non-maskable and taken whatever the enable flag
// R3 - illegal opcode instruction raises undefined-instruction interrupt at its fixed vector
// R4 - overflow trap instruction interrupts only with overflow flag set
// R5 - breakpoint uses its fixed vector, or variable entry when that holds FF
// R6 - soft trap instruction raises numbered software interrupt 0 to 63
// R7 - trap numbers 0 to 31 share vector entries with peripheral sources
// R8 - traps 0 to 31 save stack select, clear it, restore on return
// R9 - traps 32 to 63 leave stack select unchanged
// R10 - reset takes its start address from the reset fixed vector
// R11 - low nonmaskable pin raises non-maskable interrupt at its fixed vector
// R12 - software rewrites watchdog start register after watchdog interrupt
// R13 - debug flag set gives single-step interrupt after each instruction
// R14 - address match enabled interrupts just before instruction at match address
// R15 - no match interrupt unless match address is an instruction's first byte
// R16 - debugger break interrupt has its own fixed vector, debugger only
// R17 - peripheral interrupts are maskable
// R18 - low key input pin raises the maskable key interrupt
// R19 - external pins interrupt on rising, falling or both edges
// R20 - fixed vectors span the top region, four bytes each, branched through
// R21 - variable vectors sit at vector base, four bytes per trap number
// R22 - maskable accepted when enabled, requested and level above processor level
module isvu_top
	import isvu_pkg::*;
(
	input  wire logic               pclk,              // cpu clock, 25 MHz
	input  wire logic               presetn,           // async reset, low active
	input  wire logic               psel,              // apb select
	input  wire logic               penable,           // apb access phase
	input  wire logic               pwrite,            // apb write
	input  wire logic [APB_AW-1:0]  paddr,             // apb byte address
	input  wire logic [31:0]        pwdata,            // apb write data
	output logic      [31:0]        prdata,            // apb read data
	output logic                    pready,            // apb ready
	output logic                    pslverr,           // apb error, unmapped
	input  wire isvu_cpu_t          cpu,               // core events and flags
	output isvu_take_t              take_o,            // accepted interrupt
	input  wire logic               nonmaskable_pin_n, // nmi pin, low active
	input  wire logic               key_input_pin_n,   // key pin, low active
	input  wire logic [NEXT-1:0]    external_irq0_pin, // edge pins
	input  wire logic               watchdog_event,    // watchdog underflow pulse
	input  wire logic               debugger_break,    // debugger break pulse
	input  wire logic [NSRC-1:0]    periph_req         // peripheral request pulses
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                       nmi_s1;
		logic                       nmi_s2;
		logic                       key_s1;
		logic                       key_s2;
		logic [NEXT-1:0]            ext_s1;
		logic [NEXT-1:0]            ext_s2;
		logic [NEXT-1:0]            ext_prev;
		logic                       reset_pend;
		logic                       nmi_pend;
		logic                       dbc_pend;
		logic                       wdt_pend;
		logic                       und_pend;
		logic                       ovf_pend;
		logic                       brk_pend;
		logic                       brk_var;
		logic                       soft_pend;
		logic [NUM_W-1:0]           soft_num;
		logic                       am_pend;
		logic                       ss_pend;
		logic [NSRC-1:0]            req;
		logic [NSRC-1:0][LVL_W-1:0] lvl;
		logic [ADDR_W-1:0]          vbase;
		logic [ADDR_W-1:0]          am_addr;
		logic                       am_en;
		logic [2*NEXT-1:0]          edge_sel;
		isvu_take_t                 tk;
		logic [LVL_W-1:0]           last_lvl;
		logic                       ss_saved;
		logic                       ss_saved_v;
		logic [31:0]                rdata;
		logic                       err;
	} isvu_state_t;

	isvu_state_t s;
	isvu_state_t next_s;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// R21 - entry address in the variable table
	function automatic logic [ADDR_W-1:0] vec_of(input logic [ADDR_W-1:0] base,
	                                             input logic [NUM_W-1:0]  num);
		logic [ADDR_W-1:0] ofs;
		ofs = {{(ADDR_W-NUM_W-2){1'b0}}, num, 2'b00};
		return ADDR_W'(base + ofs);
	endfunction

	// apb address decode, shared by read setup and write access
	function automatic isvu_reg_t dec(input logic [APB_AW-1:0] a);
		isvu_reg_t r;
		r = REG_NONE;
		if (a[1:0] == 2'b00) begin
			if (a < OFS_VBASE)
				r = REG_CTRL;
			else if (a == OFS_VBASE)
				r = REG_VBASE;
			else if (a == OFS_AMADDR)
				r = REG_AMADDR;
			else if (a == OFS_AMEN)
				r = REG_AMEN;
			else if (a == OFS_EDGESEL)
				r = REG_EDGE;
			else if (a == OFS_STATUS)
				r = REG_STAT;
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata  = s.rdata;
	assign pslverr = s.err;
	// zero wait states: read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign take_o  = s.tk;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// one pass: bus, then acceptance clears, then hardware sets so
	// that a set arriving with a clear is never lost
	always_comb begin
		isvu_reg_t          rsel;
		logic [4:0]         ridx;
		logic               best_hit;
		logic [LVL_W-1:0]   best_lvl;
		logic [4:0]         best_num;
		logic               mask_ok;
		logic [NSRC-1:0]    set_req;
		logic [NEXT-1:0]    rise;
		logic [NEXT-1:0]    fall;
		mask_ok  = 1'b0;
		rise     = '0;
		fall     = '0;
		rsel     = dec(paddr);
		ridx     = paddr[6:2];
		best_hit = 1'b0;
		best_lvl = '0;
		best_num = '0;
		set_req  = periph_req;
		next_s   = s;

		// pin synchronisers; stage one feeds stage two only
		next_s.nmi_s1   = nonmaskable_pin_n;
		next_s.nmi_s2   = s.nmi_s1;
		next_s.key_s1   = key_input_pin_n;
		next_s.key_s2   = s.key_s1;
		next_s.ext_s1   = external_irq0_pin;
		next_s.ext_s2   = s.ext_s1;
		next_s.ext_prev = s.ext_s2;

		// apb setup: capture read data and error
		if (psel && !penable) begin
			next_s.err   = (rsel == REG_NONE);
			next_s.rdata = '0;
			unique case (rsel)
				REG_CTRL:   next_s.rdata = {28'h0000000, s.req[ridx], s.lvl[ridx]};
				REG_VBASE:  next_s.rdata = {12'h000, s.vbase};
				REG_AMADDR: next_s.rdata = {12'h000, s.am_addr};
				REG_AMEN:   next_s.rdata = {31'h00000000, s.am_en};
				REG_EDGE:   next_s.rdata = {26'h0000000, s.edge_sel};
				REG_STAT: begin
					next_s.rdata = {12'h000, s.tk.vector};
					next_s.rdata[STAT_KIND_LSB +: 4] = s.tk.kind;
					next_s.rdata[STAT_SSV_BIT]       = s.ss_saved;
					next_s.rdata[STAT_SS_BIT]        = s.ss_saved_v;
				end
				REG_NONE:   next_s.rdata = '0;
			endcase
		end

		// apb access: writes; request bits can only be cleared
		if (psel && penable && pwrite) begin
			unique case (rsel)
				REG_CTRL: begin
					next_s.lvl[ridx] = pwdata[LVL_W-1:0];
					if (!pwdata[REQ_BIT])
						next_s.req[ridx] = 1'b0;
				end
				REG_VBASE:  next_s.vbase    = pwdata[ADDR_W-1:0];
				REG_AMADDR: next_s.am_addr  = pwdata[ADDR_W-1:0];
				REG_AMEN:   next_s.am_en    = pwdata[0];
				REG_EDGE:   next_s.edge_sel = pwdata[2*NEXT-1:0];
				REG_STAT, REG_NONE: ;
			endcase
		end

		// R22 - maskable arbitration; ties go to the lower number
		for (int i = 0; i < NSRC; i++) begin
			if (s.req[i] && s.lvl[i] > cpu.processor_priority_level &&
			    (!best_hit || s.lvl[i] > best_lvl)) begin
				best_hit = 1'b1;
				best_lvl = s.lvl[i];
				best_num = 5'(i);
			end
		end
		// R1 - enable flag gates maskable sources only
		mask_ok = best_hit && cpu.irq_enable_flag;

		// R20 - acceptance through fixed and variable entries, non-maskable first
		// kind, vector and num hold until the next take for status reads
		next_s.tk.take    = 1'b0;
		next_s.tk.ss_load = 1'b0;
		// R10 - reset vector
		if (s.reset_pend) begin
			next_s.reset_pend = 1'b0;
			next_s.tk         = '{1'b1, K_RESET, VEC_RESET, '0, 1'b0, 1'b0};
		// R11 - nmi vector
		end else if (s.nmi_pend) begin
			next_s.nmi_pend = 1'b0;
			next_s.tk       = '{1'b1, K_NMI, VEC_NMI, '0, 1'b0, 1'b0};
		// R16 - debugger break vector
		end else if (s.dbc_pend) begin
			next_s.dbc_pend = 1'b0;
			next_s.tk       = '{1'b1, K_DBC, VEC_DBC, '0, 1'b0, 1'b0};
		// R12 - watchdog vector; restart is left to software
		end else if (s.wdt_pend) begin
			next_s.wdt_pend = 1'b0;
			next_s.tk       = '{1'b1, K_WDT, VEC_WDT, '0, 1'b0, 1'b0};
		// R3 - undefined instruction vector
		end else if (s.und_pend) begin
			next_s.und_pend = 1'b0;
			next_s.tk       = '{1'b1, K_UND, VEC_UND, '0, 1'b0, 1'b0};
		end else if (s.ovf_pend) begin
			next_s.ovf_pend = 1'b0;
			next_s.tk       = '{1'b1, K_OVF, VEC_OVF, '0, 1'b0, 1'b0};
		// R5 - breakpoint falls back to variable entry
		end else if (s.brk_pend) begin
			next_s.brk_pend = 1'b0;
			next_s.tk = '{1'b1, K_BRK,
			              s.brk_var ? vec_of(s.vbase, BRK_VAR_NUM) : VEC_BRK,
			              '0, 1'b0, 1'b0};
		// R6 - numbered software trap
		end else if (s.soft_pend) begin
			next_s.soft_pend = 1'b0;
			// R7 - shared entries through the variable table
			next_s.tk = '{1'b1, K_SOFT, vec_of(s.vbase, s.soft_num), s.soft_num,
			              1'b0, 1'b0};
			// R8 - save and clear stack select for shared numbers
			if (s.soft_num < SHARED_LIMIT) begin
				next_s.tk.ss_load = 1'b1;
				next_s.ss_saved   = cpu.stack_select_flag;
				next_s.ss_saved_v = 1'b1;
			end
			// R9 - upper numbers leave it alone
		// R14 - address match vector
		end else if (s.am_pend) begin
			next_s.am_pend = 1'b0;
			next_s.tk      = '{1'b1, K_AMATCH, VEC_AMATCH, '0, 1'b0, 1'b0};
		// R13 - single step vector
		end else if (s.ss_pend) begin
			next_s.ss_pend = 1'b0;
			next_s.tk      = '{1'b1, K_SSTEP, VEC_SSTEP, '0, 1'b0, 1'b0};
		// R17 - peripheral and pin sources only via the mask
		end else if (mask_ok) begin
			next_s.req[best_num] = 1'b0;
			next_s.last_lvl      = best_lvl;
			next_s.tk = '{1'b1, K_MASK, vec_of(s.vbase, {1'b0, best_num}),
			              {1'b0, best_num}, 1'b0, 1'b0};
		end else if (cpu.reti && s.ss_saved_v) begin
			// R8 - restore on return; one saved level only
			next_s.ss_saved_v  = 1'b0;
			next_s.tk.ss_load  = 1'b1;
			next_s.tk.ss_value = s.ss_saved;
		end

		// R11 - low level on the synchronised pin
		if (!s.nmi_s2)
			next_s.nmi_pend = 1'b1;
		if (debugger_break)
			next_s.dbc_pend = 1'b1;
		if (watchdog_event)
			next_s.wdt_pend = 1'b1;

		// R2 - trap instructions ignore enable flag and levels
		if (cpu.instr_done) begin
			unique case (cpu.instr_kind)
				INS_ILLEGAL: next_s.und_pend = 1'b1;
				// R4 - only with overflow flag set
				INS_OVF_TRAP: begin
					if (cpu.overflow_flag)
						next_s.ovf_pend = 1'b1;
				end
				INS_BREAK: begin
					next_s.brk_pend = 1'b1;
					next_s.brk_var  = cpu.brk_vector_ff;
				end
				INS_SOFT_TRAP: begin
					next_s.soft_pend = 1'b1;
					next_s.soft_num  = cpu.trap_num;
				end
				INS_OTHER: ;
			endcase
			// R13 - step after every instruction
			if (cpu.debug_flag)
				next_s.ss_pend = 1'b1;
		end

		// R15 - compared only against instruction start addresses
		if (cpu.insn_start && s.am_en && cpu.insn_addr == s.am_addr)
			next_s.am_pend = 1'b1;

		// R18 - key pin level request
		if (!s.key_s2)
			set_req[SLOT_KEY] = 1'b1;
		// R19 - per-pin edge choice
		rise = s.ext_s2 & ~s.ext_prev;
		fall = ~s.ext_s2 & s.ext_prev;
		for (int k = 0; k < NEXT; k++) begin
			unique case (s.edge_sel[2*k +: 2])
				EDGE_FALL: set_req[SLOT_EXT0+k] = set_req[SLOT_EXT0+k] | fall[k];
				EDGE_RISE: set_req[SLOT_EXT0+k] = set_req[SLOT_EXT0+k] | rise[k];
				default:   set_req[SLOT_EXT0+k] = set_req[SLOT_EXT0+k] | rise[k] | fall[k];
			endcase
		end
		next_s.req = next_s.req | set_req;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// reset_pend comes up set so the reset vector is issued first;
	// pin stages reset high to match idle pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s            <= '0;
			s.reset_pend <= 1'b1;
			s.nmi_s1     <= 1'b1;
			s.nmi_s2     <= 1'b1;
			s.key_s1     <= 1'b1;
			s.key_s2     <= 1'b1;
			// idle-high pins: no false edge after reset
			s.ext_s1     <= '1;
			s.ext_s2     <= '1;
			s.ext_prev   <= '1;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence q_nmi_low;
		!nonmaskable_pin_n [*3];
	endsequence

	sequence q_nmi_taken;
		take_o.take && take_o.kind == K_NMI && take_o.vector == VEC_NMI;
	endsequence

	// R10 - first acceptance after reset is the reset vector
	property p_reset_first;
		@(posedge pclk) disable iff (!presetn)
		s.reset_pend |=> take_o.take && take_o.vector == VEC_RESET;
	endproperty
	a_reset_first: assert property (p_reset_first) else $error("reset vector not issued"); // R10

	property p_nmi;
		@(posedge pclk) disable iff (!presetn)
		q_nmi_low |-> ##[1:4] q_nmi_taken;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi not taken"); // R11

	property p_mask_gate;
		@(posedge pclk) disable iff (!presetn)
		take_o.take && take_o.kind == K_MASK |-> $past(cpu.irq_enable_flag) &&
			s.last_lvl > $past(cpu.processor_priority_level);
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("maskable taken while gated"); // R22

	property p_ss_clear;
		@(posedge pclk) disable iff (!presetn)
		take_o.take && take_o.kind == K_SOFT && take_o.num < SHARED_LIMIT |->
			take_o.ss_load && !take_o.ss_value && s.ss_saved_v;
	endproperty
	a_ss_clear: assert property (p_ss_clear) else $error("stack select not cleared"); // R8

	property p_ss_keep;
		@(posedge pclk) disable iff (!presetn)
		take_o.take && take_o.kind == K_SOFT && take_o.num >= SHARED_LIMIT |-> !take_o.ss_load;
	endproperty
	a_ss_keep: assert property (p_ss_keep) else $error("stack select touched"); // R9

	property p_ovf_cause;
		@(posedge pclk) disable iff (!presetn)
		$rose(s.ovf_pend) |-> $past(cpu.instr_done && cpu.instr_kind == INS_OVF_TRAP &&
			cpu.overflow_flag);
	endproperty
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without flag"); // R4

	property p_soft_vec;
		@(posedge pclk) disable iff (!presetn)
		take_o.take && take_o.kind == K_SOFT |->
			take_o.vector == vec_of(s.vbase, take_o.num);
	endproperty
	a_soft_vec: assert property (p_soft_vec) else $error("soft trap vector wrong"); // R21

	property p_und;
		@(posedge pclk) disable iff (!presetn)
		cpu.instr_done && cpu.instr_kind == INS_ILLEGAL && !s.reset_pend && !s.nmi_pend &&
			!s.dbc_pend && !s.wdt_pend && nonmaskable_pin_n && !debugger_break &&
			!watchdog_event
		|-> ##2 take_o.take && take_o.vector == VEC_UND;
	endproperty
	a_und: assert property (p_und) else $error("undefined instruction not vectored"); // R3

	property p_amatch;
		@(posedge pclk) disable iff (!presetn)
		cpu.insn_start && s.am_en && cpu.insn_addr == s.am_addr |=> s.am_pend;
	endproperty
	a_amatch: assert property (p_amatch) else $error("address match missed"); // R14

endmodule

//--- include/isvu_pkg.sv
package isvu_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W   = 20;
	localparam int NSRC     = 32;
	localparam int LVL_W    = 3;
	localparam int NUM_W    = 6;
	localparam int NEXT     = 3;
	localparam int APB_AW   = 12;

	// ------------------------------------------------------------
	// fixed vector entries, four bytes each
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] VEC_UND    = 20'hfffdc;
	localparam logic [ADDR_W-1:0] VEC_OVF    = 20'hfffe0;
	localparam logic [ADDR_W-1:0] VEC_BRK    = 20'hfffe4;
	localparam logic [ADDR_W-1:0] VEC_AMATCH = 20'hfffe8;
	localparam logic [ADDR_W-1:0] VEC_SSTEP  = 20'hfffec;
	localparam logic [ADDR_W-1:0] VEC_WDT    = 20'hffff0;
	localparam logic [ADDR_W-1:0] VEC_DBC    = 20'hffff4;
	localparam logic [ADDR_W-1:0] VEC_NMI    = 20'hffff8;
	localparam logic [ADDR_W-1:0] VEC_RESET  = 20'hffffc;

	// soft trap numbers below this one share slots with peripherals
	localparam logic [NUM_W-1:0]  SHARED_LIMIT = 6'h20;
	localparam logic [NUM_W-1:0]  BRK_VAR_NUM  = 6'h00;

	// fixed slots for pin-driven maskable sources
	localparam int SLOT_KEY  = 13;
	localparam int SLOT_EXT0 = 29;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [APB_AW-1:0] OFS_CTRL0   = 12'h000;
	localparam logic [APB_AW-1:0] OFS_VBASE   = 12'h080;
	localparam logic [APB_AW-1:0] OFS_AMADDR  = 12'h084;
	localparam logic [APB_AW-1:0] OFS_AMEN    = 12'h088;
	localparam logic [APB_AW-1:0] OFS_EDGESEL = 12'h08c;
	localparam logic [APB_AW-1:0] OFS_STATUS  = 12'h090;
	localparam int REQ_BIT = 3;
	localparam int STAT_KIND_LSB = 24;
	localparam int STAT_SSV_BIT  = 30;
	localparam int STAT_SS_BIT   = 31;

	// edge select per external pin
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		INS_OTHER, INS_ILLEGAL, INS_OVF_TRAP, INS_BREAK, INS_SOFT_TRAP
	} isvu_instr_t;

	typedef enum logic [3:0] {
		K_NONE, K_RESET, K_NMI, K_DBC, K_WDT, K_UND, K_OVF, K_BRK,
		K_SOFT, K_AMATCH, K_SSTEP, K_MASK
	} isvu_kind_t;

	typedef enum logic [2:0] {
		REG_NONE, REG_CTRL, REG_VBASE, REG_AMADDR, REG_AMEN, REG_EDGE, REG_STAT
	} isvu_reg_t;

	typedef struct packed {
		logic              instr_done;
		isvu_instr_t       instr_kind;
		logic [NUM_W-1:0]  trap_num;
		logic              overflow_flag;
		logic              brk_vector_ff;
		logic              insn_start;
		logic [ADDR_W-1:0] insn_addr;
		logic              debug_flag;
		logic              irq_enable_flag;
		logic [LVL_W-1:0]  processor_priority_level;
		logic              stack_select_flag;
		logic              reti;
	} isvu_cpu_t;

	typedef struct packed {
		logic              take;
		isvu_kind_t        kind;
		logic [ADDR_W-1:0] vector;
		logic [NUM_W-1:0]  num;
		logic              ss_load;
		logic              ss_value;
	} isvu_take_t;

endpackage

//--- verification/isvu_core_model.sv
`timescale 1ns/1ps
module isvu_core_model
	import isvu_pkg::*;
(
	input  wire logic       pclk,       // cpu clock
	input  wire logic       presetn,    // async reset, low active
	input  wire isvu_take_t take_o,     // accepted interrupt from the unit
	output logic            ss_flag,    // stack select flag held by the core
	output logic            wdt_restart // handler restarted the watchdog
);
	// ------------------------------------------------------------
	// core flag state
	// ------------------------------------------------------------
	// starts on the user stack so that a clear to 0 is visible
	// flag load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_flag <= 1'b1;
		end else if (take_o.ss_load) begin
			ss_flag <= take_o.ss_value;
		end
	end
	// watchdog restart
	// the handler's store to the start register is reduced to a flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_restart <= 1'b0;
		end else if (take_o.take && take_o.kind == K_WDT) begin
			wdt_restart <= 1'b1;
		end
	end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import isvu_pkg::*;
;
	localparam logic [19:0] BASE = 20'h40000;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	isvu_cpu_t         cpu_drv, cpu_in;
	isvu_take_t        take_o;
	logic              nmi_n, key_n, ss_flag, wdt_restart, wdog, dbg_brk;
	logic [NEXT-1:0]   ext_pin;
	logic [NSRC-1:0]   periph_req;
	int                err_total, n_checks;

	// ------------------------------------------------------------
	// harness
	// ------------------------------------------------------------
	always #20 pclk = ~pclk;
	// the core model owns the stack flag
	always_comb begin
		cpu_in = cpu_drv;
		cpu_in.stack_select_flag = ss_flag;
	end
	isvu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu(cpu_in), .take_o(take_o),
		.nonmaskable_pin_n(nmi_n), .key_input_pin_n(key_n),
		.external_irq0_pin(ext_pin), .watchdog_event(wdog),
		.debugger_break(dbg_brk), .periph_req(periph_req));
	isvu_core_model core (.pclk(pclk), .presetn(presetn), .take_o(take_o),
		.ss_flag(ss_flag), .wdt_restart(wdt_restart));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// holds the request until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic exp_take(input isvu_kind_t k, input logic [19:0] v);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (take_o.take !== 1'b1 && n < 12);
		check(take_o.take, 1'b1);
		check(take_o.kind, k);
		check(take_o.vector, v);
	endtask
	task automatic no_take(input int n);
		repeat (n) begin
			@(posedge pclk);
			#1;
			check(take_o.take, 1'b0);
		end
	endtask
	task automatic instr(input isvu_instr_t k, input logic [5:0] num, input logic ovf,
		input logic ff);
		@(posedge pclk);
		cpu_drv.instr_done <= 1'b1;
		cpu_drv.instr_kind <= k;
		cpu_drv.trap_num <= num;
		cpu_drv.overflow_flag <= ovf;
		cpu_drv.brk_vector_ff <= ff;
		@(posedge pclk);
		cpu_drv.instr_done <= 1'b0;
	endtask
	task automatic start_at(input logic [19:0] a);
		@(posedge pclk);
		cpu_drv.insn_start <= 1'b1;
		cpu_drv.insn_addr <= a;
		@(posedge pclk);
		cpu_drv.insn_start <= 1'b0;
	endtask
	task automatic set_ext(input logic v);
		@(posedge pclk);
		ext_pin[0] <= v;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_soft();
		instr(INS_SOFT_TRAP, 6'd5, 1'b0, 1'b0);
		exp_take(K_SOFT, BASE + 20'd20);
		check(take_o.num, 6'd5);
		check({take_o.ss_load, take_o.ss_value}, 2'b10);
		@(posedge pclk);
		#1;
		check(ss_flag, 1'b0);
		@(posedge pclk);
		cpu_drv.reti <= 1'b1;
		@(posedge pclk);
		cpu_drv.reti <= 1'b0;
		#1;
		check({take_o.take, take_o.ss_load, take_o.ss_value}, 3'b011);
		instr(INS_SOFT_TRAP, 6'd40, 1'b0, 1'b0);
		exp_take(K_SOFT, BASE + 20'd160);
		check(take_o.ss_load, 1'b0);
	endtask
	// trap kinds run with the enable flag still clear
	task automatic t_traps();
		instr(INS_ILLEGAL, 6'd0, 1'b0, 1'b0);
		exp_take(K_UND, VEC_UND);
		instr(INS_OVF_TRAP, 6'd0, 1'b1, 1'b0);
		exp_take(K_OVF, VEC_OVF);
		instr(INS_OVF_TRAP, 6'd0, 1'b0, 1'b0);
		no_take(4);
		instr(INS_BREAK, 6'd0, 1'b0, 1'b0);
		exp_take(K_BRK, VEC_BRK);
		instr(INS_BREAK, 6'd0, 1'b0, 1'b1);
		exp_take(K_BRK, BASE);
		@(posedge pclk);
		cpu_drv.debug_flag <= 1'b1;
		instr(INS_OTHER, 6'd0, 1'b0, 1'b0);
		exp_take(K_SSTEP, VEC_SSTEP);
		@(posedge pclk);
		cpu_drv.debug_flag <= 1'b0;
		instr(INS_OTHER, 6'd0, 1'b0, 1'b0);
		no_take(4);
		apb(1'b1, OFS_AMADDR, 32'h1234);
		apb(1'b1, OFS_AMEN, 32'h1);
		start_at(20'h01233);
		no_take(4);
		start_at(20'h01234);
		exp_take(K_AMATCH, VEC_AMATCH);
		apb(1'b1, OFS_AMEN, 32'h0);
	endtask
	task automatic t_special();
		@(posedge pclk);
		nmi_n <= 1'b0;
		exp_take(K_NMI, VEC_NMI);
		@(posedge pclk);
		nmi_n <= 1'b1;
		repeat (8) @(posedge pclk);
		wdog <= 1'b1;
		@(posedge pclk);
		wdog <= 1'b0;
		exp_take(K_WDT, VEC_WDT);
		@(posedge pclk);
		dbg_brk <= 1'b1;
		@(posedge pclk);
		dbg_brk <= 1'b0;
		exp_take(K_DBC, VEC_DBC);
		check(wdt_restart, 1'b1);
	endtask
	task automatic t_mask();
		apb(1'b1, 12'h028, 32'h3);
		@(posedge pclk);
		periph_req[10] <= 1'b1;
		@(posedge pclk);
		periph_req[10] <= 1'b0;
		no_take(4);
		@(posedge pclk);
		cpu_drv.irq_enable_flag <= 1'b1;
		cpu_drv.processor_priority_level <= 3'd3;
		no_take(4);
		@(posedge pclk);
		cpu_drv.processor_priority_level <= 3'd2;
		exp_take(K_MASK, BASE + 20'd40);
		check(take_o.num, 6'd10);
		apb(1'b0, OFS_STATUS, 32'h0);
		check({rd[27:24], rd[19:0]}, {K_MASK, BASE + 20'd40});
		apb(1'b0, 12'h028, 32'h0);
		check(rd[REQ_BIT], 1'b0);
		apb(1'b0, 12'h0a0, 32'h0);
		check(err, 1'b1);
	endtask
	task automatic t_pins();
		apb(1'b1, 12'h034, 32'h4);
		@(posedge pclk);
		key_n <= 1'b0;
		exp_take(K_MASK, BASE + 20'd52);
		@(posedge pclk);
		key_n <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b1, 12'h034, 32'h0);
		apb(1'b1, 12'h074, 32'h5);
		apb(1'b1, OFS_EDGESEL, {30'h0, EDGE_RISE});
		set_ext(1'b0);
		no_take(6);
		set_ext(1'b1);
		exp_take(K_MASK, BASE + 20'd116);
		apb(1'b1, OFS_EDGESEL, {30'h0, EDGE_FALL});
		set_ext(1'b0);
		exp_take(K_MASK, BASE + 20'd116);
		apb(1'b1, OFS_EDGESEL, 32'h2);
		set_ext(1'b1);
		exp_take(K_MASK, BASE + 20'd116);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// a hang ends the run well past the expected few hundred cycles
	initial begin
		#200000;
		err_total++;
		final_report();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		cpu_drv = '0;
		nmi_n = 1'b1;
		key_n = 1'b1;
		ext_pin = '1;
		wdog = 1'b0;
		dbg_brk = 1'b0;
		periph_req = '0;
		err_total = 0;
		n_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		exp_take(K_RESET, VEC_RESET);
		apb(1'b1, OFS_VBASE, {12'h0, BASE});
		t_soft();
		t_traps();
		t_special();
		t_mask();
		t_pins();
		final_report();
	end
endmodule
